// ### core/omr_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Operating mode control register with stack-extension and external-bus control.
module mrs_ctrl (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic omr_wr_i,
	input wire logic [23:0] omr_wdata_i,
	output logic [23:0] omr_rdata_o,
	input wire logic pull_req_i,
	input wire logic [5:0] stack_pointer_i,
	output logic stack_underflow_bit_counts_o,
	output logic stack_ext_active_o,
	output logic stack_space_y_o,
	output logic stack_error_o,
	output logic [3:0] stack_error_level_o,
	input wire logic int_access_i,
	input wire logic [23:0] int_addr_i,
	input wire logic ext_access_i,
	input wire logic [23:0] ext_addr_i,
	output logic [23:0] bus_addr_o,
	input wire logic [3:0] strobe_match_i,
	output logic [3:0] address_attribute_strobes_n_o,
	input wire logic bus_grant_n_i,
	input wire logic bus_busy_n_i,
	output logic bus_owned_o,
	output logic bus_busy_n_o,
	output logic bus_busy_oe_n_o,
	input wire logic xfer_start_i,
	input wire logic transfer_acknowledge_n_i,
	output logic xfer_done_o,
	output logic port_oe_n_o
);

	// State of the block outside the synchronisers: mode word, bus sequencer and pin drivers.
	typedef struct packed {
		logic [23:0] mode;
		mrs_pkg::mrs_bus_st_t st;
		logic err;
		logic [23:0] addr;
		logic [3:0] strobe_n;
		logic busy_oe_n;
		logic port_oe_n;
	} mrs_state_t;

	// Synchronised copies of the low-true bus inputs.
	logic grant_sync;
	logic busy_sync;
	logic ack_sync;

	// Effective inputs after the per-mode synchroniser choice.
	logic grant_n;
	logic busy_n;
	logic ack_n;

	// Pull with an empty pointer while the extension is on.
	logic underflow_evt;

	// One-hot result of the fixed strobe priority.
	logic [3:0] prio;

	mrs_state_t r_q;
	mrs_state_t r_d;

	// Grant synchroniser, used only in asynchronous arbitration.
	mrs_sync u_grant (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(bus_grant_n_i),
		.q_o(grant_sync)
	);

	// Busy synchroniser, used only in asynchronous arbitration.
	mrs_sync u_busy (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(bus_busy_n_i),
		.q_o(busy_sync)
	);

	// Acknowledge synchroniser; deassertion must still be clock-aligned outside.
	mrs_sync u_ack (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(transfer_acknowledge_n_i),
		.q_o(ack_sync)
	);

	// async arbitration path
	// Synchronising adds two cycles of latency on grant and busy.
	assign grant_n = r_q.mode[mrs_pkg::BIT_ASYNC_ARB] ? grant_sync : bus_grant_n_i;
	assign busy_n = r_q.mode[mrs_pkg::BIT_ASYNC_ARB] ? busy_sync : bus_busy_n_i;

	// acknowledge sync choice
	// With the bit clear the raw pin is used, so it must meet setup outside.
	assign ack_n = r_q.mode[mrs_pkg::BIT_ACK_SYNC] ? ack_sync : transfer_acknowledge_n_i;

	// underflow detection
	// Only a pull at pointer zero with the extension on counts as underflow.
	assign underflow_evt = pull_req_i && r_q.mode[mrs_pkg::BIT_EXT_EN]
		&& (stack_pointer_i == 6'h00);

	always_comb begin
		prio = 4'h0;
		if (strobe_match_i[3]) begin
			prio = 4'h8;
		end else if (strobe_match_i[2]) begin
			prio = 4'h4;
		end else if (strobe_match_i[1]) begin
			prio = 4'h2;
		end else if (strobe_match_i[0]) begin
			prio = 4'h1;
		end
	end

	// Next-state logic for register, bus sequencer and pin drivers.
	always_comb begin
		r_d = r_q;
		r_d.err = 1'b0;

		// sticky flag write
		// Besides an underflow setting the flag, only a control-register move changes the word; reserved bits stay zero.
		if (omr_wr_i) begin
			r_d.mode = omr_wdata_i & mrs_pkg::MODE_WMASK;
		end

		// set wins over write
		// A clear and an underflow in one cycle leave the flag set.
		if (underflow_evt) begin
			r_d.mode[mrs_pkg::BIT_UNF] = 1'b1;
		end

		// rising flag exception
		// The error pulse marks only the zero-to-one step of the flag.
		r_d.err = r_d.mode[mrs_pkg::BIT_UNF] && !r_q.mode[mrs_pkg::BIT_UNF];

		// address trace mux
		// An external access keeps the lines; trace fills only idle cycles.
		if (ext_access_i) begin
			r_d.addr = ext_addr_i;
		end else if (int_access_i && r_q.mode[mrs_pkg::BIT_TRC]) begin
			r_d.addr = int_addr_i;
		end

		// priority disable
		// With priority off every matching strobe goes low together.
		r_d.strobe_n = r_q.mode[mrs_pkg::BIT_PRIO_DIS] ? ~strobe_match_i : ~prio;

		// Bus sequencer: take the bus, wait for acknowledge, then release.
		unique case (r_q.st)
			mrs_pkg::BUS_IDLE: begin
				r_d.busy_oe_n = 1'b1;
				r_d.port_oe_n = 1'b1;
				if (xfer_start_i && !grant_n && busy_n) begin
					r_d.st = mrs_pkg::BUS_XFER;
					r_d.busy_oe_n = 1'b0;
					r_d.port_oe_n = 1'b0;
				end
			end
			mrs_pkg::BUS_XFER: begin
				if (!ack_n) begin
					if (r_q.mode[mrs_pkg::BIT_REL_SLOW]) begin
						r_d.st = mrs_pkg::BUS_RELEASE;
						r_d.port_oe_n = 1'b1;
					end else begin
						r_d.st = mrs_pkg::BUS_IDLE;
						r_d.port_oe_n = 1'b1;
						r_d.busy_oe_n = 1'b1;
					end
				end
			end
			mrs_pkg::BUS_RELEASE: begin
				r_d.st = mrs_pkg::BUS_IDLE;
				r_d.busy_oe_n = 1'b1;
			end
		endcase
	end

	// State register with reset values.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_q.mode <= mrs_pkg::MODE_RESET;
			r_q.st <= mrs_pkg::BUS_IDLE;
			r_q.err <= 1'b0;
			r_q.addr <= 24'h000000;
			r_q.strobe_n <= 4'hf;
			r_q.busy_oe_n <= 1'b1;
			r_q.port_oe_n <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	// Register read-back straight from the flip-flops.
	assign omr_rdata_o = r_q.mode;

	assign stack_ext_active_o = r_q.mode[mrs_pkg::BIT_EXT_EN];

	// counter bit behaviour
	// In extension mode the pointer's top bit counts instead of flagging.
	assign stack_underflow_bit_counts_o = r_q.mode[mrs_pkg::BIT_EXT_EN];

	assign stack_space_y_o = r_q.mode[mrs_pkg::BIT_SPACE];

	// Stack error pulse and its fixed level.
	assign stack_error_o = r_q.err;
	assign stack_error_level_o = mrs_pkg::STACK_ERR_LEVEL;

	// Address lines and strobes, all registered.
	assign bus_addr_o = r_q.addr;
	assign address_attribute_strobes_n_o = r_q.strobe_n;

	// Busy is open-drain: the level is always low, the enable does the work.
	assign bus_busy_n_o = 1'b0;
	assign bus_busy_oe_n_o = r_q.busy_oe_n;
	assign port_oe_n_o = r_q.port_oe_n;

	// Handshake outputs decoded from the sequencer state; done also needs the effective acknowledge.
	assign bus_owned_o = (r_q.st != mrs_pkg::BUS_IDLE);
	assign xfer_done_o = (r_q.st == mrs_pkg::BUS_XFER) && !ack_n;

endmodule // mrs_ctrl
`default_nettype wire

// ### core/omr_pkg.sv
package mrs_pkg;

	localparam int MODE_W = 24;
	localparam logic [23:0] MODE_RESET = 24'h000300;
	localparam logic [23:0] MODE_WMASK = 24'h1fffbf;
	localparam int BIT_EXT_EN = 20;
	localparam int BIT_OVF = 18;
	localparam int BIT_UNF = 17;
	localparam int BIT_SPACE = 16;
	localparam int BIT_TRC = 15;
	localparam int BIT_PRIO_DIS = 14;
	localparam int BIT_ASYNC_ARB = 13;
	localparam int BIT_REL_SLOW = 12;
	localparam int BIT_ACK_SYNC = 11;
	localparam int PTR_W = 6;
	localparam logic [3:0] STACK_ERR_LEVEL = 4'h3;
	localparam logic [1:0] SYNC_ZERO = 2'h0;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_XFER,
		BUS_RELEASE
	} mrs_bus_st_t;

endpackage : mrs_pkg

// ### core/omr_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser for one asynchronous level.
module mrs_sync (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);

	typedef struct packed {
		logic s1;
		logic s2;
	} mrs_sync_st_t;

	mrs_sync_st_t s_q;
	mrs_sync_st_t s_d;

	// First stage feeds only the second stage.
	always_comb begin
		s_d.s1 = d_i;
		s_d.s2 = s_q.s1;
	end

	// Registers reset to idle-high, matching inactive low-true bus pins.
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o = s_q.s2;

endmodule // mrs_sync
`default_nettype wire

// ### bench/omr_ctrl_checker.sv
`timescale 1ns/1ns
`default_nettype none
// Watches the mode register and the bus pins of the control block.
module mrs_chk (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic omr_wr_i,
	input wire logic pull_req_i,
	input wire logic [5:0] stack_pointer_i,
	input wire logic [23:0] omr_rdata_o,
	input wire logic stack_ext_active_o,
	input wire logic stack_space_y_o,
	input wire logic stack_error_o,
	input wire logic [3:0] stack_error_level_o,
	input wire logic [3:0] strobe_match_i,
	input wire logic [3:0] address_attribute_strobes_n_o,
	input wire logic xfer_done_o,
	input wire logic bus_busy_oe_n_o,
	input wire logic port_oe_n_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_unf_set: assert property (pull_req_i && stack_ext_active_o && stack_pointer_i == 6'h00
		|=> omr_rdata_o[17]) else $error("underflow flag not set");
	a_unf_sticky: assert property (omr_rdata_o[17] && !omr_wr_i |=> omr_rdata_o[17])
		else $error("underflow flag lost");
	a_err_rise: assert property (stack_error_o |-> omr_rdata_o[17] && !$past(omr_rdata_o[17]))
		else $error("stack error without flag rise");
	a_err_level: assert property (stack_error_level_o == 4'h3) else $error("error level wrong");
	a_ext_follow: assert property (stack_ext_active_o == omr_rdata_o[20])
		else $error("extension active mismatch");
	a_space_sel: assert property (stack_space_y_o == omr_rdata_o[16]) else $error("space mismatch");
	a_prio_one: assert property (!omr_rdata_o[14] && !$past(omr_rdata_o[14])
		|-> $onehot0(~address_attribute_strobes_n_o)) else $error("several strobes active");
	a_prio_top: assert property (strobe_match_i[3] && !omr_rdata_o[14]
		|=> !address_attribute_strobes_n_o[3]) else $error("top strobe lost");
	a_fast_rel: assert property (xfer_done_o && !omr_rdata_o[12]
		|=> port_oe_n_o && bus_busy_oe_n_o) else $error("fast release late");
	a_slow_rel: assert property (xfer_done_o && omr_rdata_o[12]
		|=> port_oe_n_o && !bus_busy_oe_n_o ##1 bus_busy_oe_n_o) else $error("slow release wrong");
	// Main scenarios reached.
	cover property (stack_error_o);
	cover property (xfer_done_o && omr_rdata_o[12]);
	cover property (omr_rdata_o[14] && strobe_match_i == 4'hf);
endmodule // mrs_chk
bind mrs_ctrl mrs_chk u_chk (.mclk_i, .rst_n_i, .omr_wr_i, .pull_req_i, .stack_pointer_i,
	.omr_rdata_o, .stack_ext_active_o, .stack_space_y_o, .stack_error_o, .stack_error_level_o,
	.strobe_match_i, .address_attribute_strobes_n_o, .xfer_done_o, .bus_busy_oe_n_o, .port_oe_n_o);
`default_nettype wire

// ### bench/omr_partner.sv
`timescale 1ns/1ns
`default_nettype none
// Far side of the bus: a lone arbiter and a memory that acknowledges after a wait.
module mrs_partner (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic port_oe_n_i,
	input wire logic [1:0] wait_i,
	output logic bus_grant_n_o,
	output logic transfer_acknowledge_n_o
);
	logic [1:0] cnt_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_grant_n_o <= 1'b1;
			transfer_acknowledge_n_o <= 1'b1;
			cnt_q <= 2'h0;
		end else begin
			bus_grant_n_o <= 1'b0;
			transfer_acknowledge_n_o <= !(!port_oe_n_i && transfer_acknowledge_n_o && cnt_q == wait_i);
			cnt_q <= (port_oe_n_i) ? 2'h0 : ((cnt_q == 2'h3) ? cnt_q : cnt_q + 2'h1);
		end
	end
endmodule // mrs_partner
`default_nettype wire

// ### bench/mode_reg_stack_bus_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
// Drives the mode control block and its bus partner through each mode.
module mode_reg_stack_bus_ctrl_bench;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, omr_wr_i = 1'b0, pull_req_i = 1'b0, xfer_start_i = 1'b0;
	logic int_access_i = 1'b0, ext_access_i = 1'b0, bus_busy_n_i, bus_grant_n_i;
	logic [23:0] omr_wdata_i = 24'h0, int_addr_i = 24'h0, ext_addr_i = 24'h0, omr_rdata_o, bus_addr_o;
	logic [5:0] stack_pointer_i = 6'h0;
	logic [3:0] strobe_match_i = 4'h0, stack_error_level_o, address_attribute_strobes_n_o;
	logic [1:0] wait_q = 2'h0;
	logic stack_underflow_bit_counts_o, stack_ext_active_o, stack_space_y_o, stack_error_o;
	logic bus_owned_o, bus_busy_n_o, bus_busy_oe_n_o, transfer_acknowledge_n_i, xfer_done_o;
	logic port_oe_n_o;
	int bad_count = 0, checks = 0;
	// Strobe rows: priority disable, match, expected low-active strobes.
	logic [8:0] rows [6] = '{9'h05b, 9'h0f7, 9'h03d, 9'h00f, 9'h15a, 9'h1f0};
	// Busy line is pulled up when nobody drives it.
	assign bus_busy_n_i = bus_busy_oe_n_o ? 1'b1 : bus_busy_n_o;
	mrs_ctrl DUT (.mclk_i, .rst_n_i, .omr_wr_i, .omr_wdata_i, .omr_rdata_o, .pull_req_i,
		.stack_pointer_i, .stack_underflow_bit_counts_o, .stack_ext_active_o, .stack_space_y_o,
		.stack_error_o, .stack_error_level_o, .int_access_i, .int_addr_i, .ext_access_i,
		.ext_addr_i, .bus_addr_o, .strobe_match_i, .address_attribute_strobes_n_o,
		.bus_grant_n_i, .bus_busy_n_i, .bus_owned_o, .bus_busy_n_o, .bus_busy_oe_n_o,
		.xfer_start_i, .transfer_acknowledge_n_i, .xfer_done_o, .port_oe_n_o);
	mrs_partner u_far (.mclk_i, .rst_n_i, .port_oe_n_i(port_oe_n_o), .wait_i(wait_q),
		.bus_grant_n_o(bus_grant_n_i), .transfer_acknowledge_n_o(transfer_acknowledge_n_i));
	initial forever #25 mclk_i = ~mclk_i;
	task automatic tick;
		@(posedge mclk_i);
		#1;
	endtask
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [23:0] v);
		omr_wr_i = 1'b1;
		omr_wdata_i = v;
		tick;
		omr_wr_i = 1'b0;
	endtask
	task automatic pull(input logic [5:0] ptr);
		stack_pointer_i = ptr;
		pull_req_i = 1'b1;
		tick;
		pull_req_i = 1'b0;
	endtask
	task automatic xfer(input logic [23:0] cfg, input logic [1:0] w);
		int i;
		wr(cfg);
		wait_q = w;
		xfer_start_i = 1'b1;
		for (i = 0; i < 20 && xfer_done_o !== 1'b1; i++) tick;
		chk("done", 24'h1, 24'(xfer_done_o));
		chk("owned", 24'h1, 24'(bus_owned_o));
		xfer_start_i = 1'b0;
		repeat (4) tick;
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Stops a hung run.
	initial begin
		#100000;
		bad_count++;
		wrap_up;
	end
	// Main sequence.
	initial begin
		repeat (3) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		chk("reset", mrs_pkg::MODE_RESET, omr_rdata_o);
		foreach (rows[k]) begin
			wr({9'h0, rows[k][8], 14'h0});
			strobe_match_i = rows[k][7:4];
			tick;
			chk("strobes", {20'h0, rows[k][3:0]}, {20'h0, address_attribute_strobes_n_o});
		end
		pull(6'h00);
		chk("unf off", 24'h0, {23'h0, omr_rdata_o[17]});
		wr(24'h100000);
		chk("counts", 24'h1, {23'h0, stack_underflow_bit_counts_o});
		pull(6'h01);
		chk("unf sp1", 24'h0, {23'h0, omr_rdata_o[17]});
		pull(6'h00);
		chk("unf", 24'h1, {23'h0, omr_rdata_o[17]});
		chk("err", 24'h1, {23'h0, stack_error_o});
		pull(6'h00);
		chk("err again", 24'h0, {23'h0, stack_error_o});
		wr(24'h110000);
		chk("space y", 24'h1, {23'h0, stack_space_y_o});
		chk("unf clr", 24'h0, {23'h0, omr_rdata_o[17]});
		wr(24'h008000);
		int_access_i = 1'b1;
		int_addr_i = 24'h00abcd;
		tick;
		chk("trace", 24'h00abcd, bus_addr_o);
		int_access_i = 1'b0;
		xfer(24'h000000, 2'h0);
		xfer(24'h001000, 2'h2);
		xfer(24'h002800, 2'h1);
		rst_n_i = 1'b0;
		tick;
		chk("reset again", mrs_pkg::MODE_RESET, omr_rdata_o);
		wrap_up;
	end
endmodule // mode_reg_stack_bus_ctrl_bench
`default_nettype wire
